// ==== hw/pci_fb2b_defs.svh ====
`ifndef PCI_FB2B_DEFS_SVH
`define PCI_FB2B_DEFS_SVH

// burst length field width
`define FB2B_BURST_W 12
// apb register byte offsets
`define FB2B_CTRL_OFS 8'h00
`define FB2B_STATUS_OFS 8'h04
`define FB2B_XCOUNT_OFS 8'h08
// control register fields and reset value
`define FB2B_CTRL_CHAIN_BIT 0
`define FB2B_CTRL_RESET 32'h0000_0001
// status register field positions
`define FB2B_STATUS_STATE_LSB 0
`define FB2B_STATUS_COUNT_LSB 4
// command bit that marks a pci write command
`define FB2B_CMD_WRITE_BIT 0

`endif

// ==== hw/pci_fb2b_pkg.sv ====
package pci_fb2b_pkg;

  // local status codes reported to the local master [RULE_23]
  typedef enum logic [3:0] {
    LS_IDLE = 4'b0000,
    LS_ADDR_LOAD = 4'b0001,
    LS_BUS_TRANS = 4'b0010,
    LS_FB2B = 4'b0011,
    LS_TERM = 4'b0100
  } local_state_t;

  // internal sequencer steps
  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0000,
    SQ_GRANT = 4'b0001,
    SQ_ADDR_LOAD = 4'b0010,
    SQ_ADDR = 4'b0011,
    SQ_WAIT1 = 4'b0100,
    SQ_WAIT2 = 4'b0101,
    SQ_DATA = 4'b0110,
    SQ_FBWAIT = 4'b0111,
    SQ_LAST = 4'b1000,
    SQ_TURN = 4'b1001
  } seq_t;

  // register block state
  typedef struct packed {
    logic chain_en;
    logic [31:0] xcount;
    logic [31:0] rdata;
    logic err;
  } apb_state_t;

endpackage : pci_fb2b_pkg

// ==== hw/burst_down_counter.sv ====
`timescale 1ns/100ps
module burst_down_counter import pci_fb2b_pkg::*; #(
  parameter int W = 12
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic dec,
  input wire logic [W-1:0] load_val,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t s_r, s_nxt;

  initial begin
    if (W < 2 || W > 16) $error("burst_down_counter: W out of range");
  end

  // load at the address phase, step down after each completed phase
  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.cnt = load_val;
    end else if (dec && s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;
endmodule : burst_down_counter

// ==== hw/apb_ctrl_regs.sv ====
`timescale 1ns/100ps
`include "pci_fb2b_defs.svh"
module apb_ctrl_regs import pci_fb2b_pkg::*; #(
  parameter int CNT_W = 12
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] state_in,
  input wire logic [CNT_W-1:0] count_in,
  input wire logic xact_done,
  output logic chain_en
);
  apb_state_t s_r, s_nxt;
  logic acc;
  logic hit;

  initial begin
    if (CNT_W < 1 || CNT_W > 28) $error("apb_ctrl_regs: CNT_W out of range");
  end

  // decode, read capture in setup, write and clear in access
  always_comb begin
    s_nxt = s_r;
    acc = psel && penable;
    hit = (paddr == `FB2B_CTRL_OFS) || (paddr == `FB2B_STATUS_OFS) ||
          (paddr == `FB2B_XCOUNT_OFS);
    if (psel && !penable) begin
      s_nxt.err = !hit;
      s_nxt.rdata = 32'h0000_0000;
      if (paddr == `FB2B_CTRL_OFS) begin
        s_nxt.rdata[`FB2B_CTRL_CHAIN_BIT] = s_r.chain_en;
      end else if (paddr == `FB2B_STATUS_OFS) begin
        s_nxt.rdata[`FB2B_STATUS_STATE_LSB +: 4] = state_in;
        s_nxt.rdata[`FB2B_STATUS_COUNT_LSB +: CNT_W] = count_in;
      end else if (paddr == `FB2B_XCOUNT_OFS) begin
        s_nxt.rdata = s_r.xcount;
      end
    end
    if (acc && pwrite && paddr == `FB2B_CTRL_OFS) begin
      s_nxt.chain_en = pwdata[`FB2B_CTRL_CHAIN_BIT];
    end
    // a write clears the count; a completion in the same cycle still counts
    if (acc && pwrite && paddr == `FB2B_XCOUNT_OFS) begin
      s_nxt.xcount = xact_done ? 32'h0000_0001 : 32'h0000_0000;
    end else if (xact_done) begin
      s_nxt.xcount = s_r.xcount + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{chain_en: 1'(`FB2B_CTRL_RESET >> `FB2B_CTRL_CHAIN_BIT), xcount: '0, rdata: '0,
               err: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && s_r.err;
  assign chain_en = s_r.chain_en;
endmodule : apb_ctrl_regs

// ==== hw/pci_fb2b_master.sv ====
// Notes on behaviour
// [RULE_01] consecutive transactions run with no idle between; here one idle bus cycle (address loading) sits between them
// [RULE_02] chain request must be present at address loading
// [RULE_03] local master keeps request until data done
// [RULE_04] chain only after a write transaction
// [RULE_05] request arrives with address, command, length
// [RULE_06] bus request follows local request next cycle
// [RULE_07] local grant when bus granted and idle
// [RULE_08] request plus grant: latch, status address loading
// [RULE_09] frame, req64, address, command after address loading
// [RULE_10] burst counter loads in address phase
// [RULE_11] local ready low only when data available
// [RULE_12] both taken strobes when ready before data
// [RULE_13] keep bus request while frame and request
// [RULE_14] fast target answers devsel, ack64, trdy next
// [RULE_15] local master advances address after address-phase strobes
// [RULE_16] local master holds data while strobes idle
// [RULE_17] first data wait: frame on, irdy off
// [RULE_18] one more wait cycle for width decision
// [RULE_19] width known: wide indication, grant follows gntn
// [RULE_20] data phase completes only with irdy, trdy
// [RULE_21] counter steps down after each completed phase
// [RULE_22] last phase of first transaction gets wait
// [RULE_23] local status encodings documented with the design
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "pci_fb2b_defs.svh"
module pci_fb2b_master import pci_fb2b_pkg::*; #(
  parameter int BURST_W = `FB2B_BURST_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic local_req_32bit_n,
  input wire logic local_req_wide_n,
  input wire logic [63:0] local_data_in,
  input wire logic [7:0] local_cmd_byte_en_in,
  input wire logic [BURST_W-1:0] burst_length_in,
  input wire logic local_ready_n,
  output logic local_grant_n,
  output logic [3:0] local_master_state,
  output logic low_word_taken_n,
  output logic high_word_taken_n,
  output logic wide_transfer_ind_n,
  output logic [BURST_W-1:0] burst_remaining_count,
  input wire logic gntn,
  output logic reqn,
  input wire logic framen_i,
  output logic framen_o,
  output logic framen_oe,
  input wire logic irdyn_i,
  output logic irdyn_o,
  output logic irdyn_oe,
  output logic req64n_o,
  output logic req64n_oe,
  output logic [63:0] ad_o,
  output logic ad_oe,
  output logic [7:0] cben_o,
  input wire logic devseln,
  input wire logic trdyn,
  input wire logic ack64n
);
  typedef struct packed {
    seq_t st;
    local_state_t ls;
    logic reqn;
    logic lgnt_n;
    logic framen;
    logic frame_oe;
    logic irdyn;
    logic irdy_oe;
    logic req64n;
    logic ad_oe;
    logic strobe_n;
    logic wide_ind_n;
    logic wide_req;
    logic chain;
    logic [63:0] ad;
    logic [7:0] cben;
    logic ad_valid;
    logic [63:0] hold;
    logic [7:0] hold_be;
    logic hold_valid;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [BURST_W-1:0] len;
    logic [BURST_W-1:0] take_left;
  } mst_state_t;

  mst_state_t s_r, s_nxt;
  logic req_any;
  logic bus_idle;
  logic done;
  logic take;
  logic cnt_load;
  logic cnt_dec;
  logic xact_done;
  logic chain_en;
  logic next_strobe_ok;

  initial begin
    if (BURST_W < 2 || BURST_W > 16) $error("pci_fb2b_master: BURST_W out of range");
  end

  // remaining data phases of the running burst
  burst_down_counter #(.W(BURST_W)) u_burst_cnt (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(cnt_load),
    .dec(cnt_dec),
    .load_val(s_r.len),
    .count(burst_remaining_count)
  );

  // software control and status
  apb_ctrl_regs #(.CNT_W(BURST_W)) u_regs (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .state_in(s_r.ls),
    .count_in(burst_remaining_count),
    .xact_done(xact_done),
    .chain_en(chain_en)
  );

  // sequencer, bus drivers and local data pipeline
  always_comb begin
    s_nxt = s_r;
    req_any = !local_req_wide_n || !local_req_32bit_n;
    bus_idle = framen_i && irdyn_i;
    done = !s_r.irdyn && !trdyn && s_r.irdy_oe; // [RULE_20]
    take = !s_r.strobe_n;
    cnt_load = 1'b0;
    cnt_dec = 1'b0;
    xact_done = 1'b0;
    // bus request tracks the local request, also while frame runs
    s_nxt.reqn = !req_any; // [RULE_06] [RULE_13]

    // an accepted data phase frees the bus word; a held word moves up
    if (done && s_r.ad_valid) begin
      s_nxt.ad_valid = s_r.hold_valid;
      s_nxt.ad = s_r.hold;
      s_nxt.cben = s_r.hold_be;
      s_nxt.hold_valid = 1'b0;
    end
    // words marked taken are read now; the local side held them stable
    if (take) begin // [RULE_15] [RULE_16]
      if (!s_nxt.ad_valid) begin
        s_nxt.ad = local_data_in;
        s_nxt.cben = local_cmd_byte_en_in;
        s_nxt.ad_valid = 1'b1;
      end else begin
        s_nxt.hold = local_data_in;
        s_nxt.hold_be = local_cmd_byte_en_in;
        s_nxt.hold_valid = 1'b1;
      end
      if (s_r.take_left != '0) begin
        s_nxt.take_left = s_r.take_left - BURST_W'(1);
      end
    end

    unique case (s_r.st)
      SQ_IDLE: begin
        s_nxt.ls = LS_IDLE;
        if (!gntn && bus_idle && req_any) begin
          s_nxt.lgnt_n = 1'b0; // [RULE_07]
          s_nxt.st = SQ_GRANT;
        end
      end
      SQ_GRANT: begin
        if (req_any && !s_r.lgnt_n) begin
          // address, command and length come with the request
          s_nxt.st = SQ_ADDR_LOAD; // [RULE_05]
          s_nxt.ls = LS_ADDR_LOAD; // [RULE_08]
          s_nxt.addr = local_data_in[31:0];
          s_nxt.cmd = local_cmd_byte_en_in[3:0];
          s_nxt.len = burst_length_in;
          s_nxt.wide_req = !local_req_wide_n;
        end else begin
          s_nxt.lgnt_n = 1'b1;
          s_nxt.st = SQ_IDLE;
        end
      end
      SQ_ADDR_LOAD: begin
        if (!gntn) begin
          s_nxt.st = SQ_ADDR;
          s_nxt.ls = LS_BUS_TRANS;
          s_nxt.framen = 1'b0; // [RULE_09]
          s_nxt.frame_oe = 1'b1;
          s_nxt.req64n = !s_r.wide_req;
          s_nxt.irdyn = 1'b1;
          s_nxt.irdy_oe = 1'b1;
          s_nxt.ad = {32'h0000_0000, s_r.addr};
          s_nxt.cben = {4'h0, s_r.cmd};
          s_nxt.ad_oe = 1'b1;
          s_nxt.ad_valid = 1'b0;
          s_nxt.hold_valid = 1'b0;
          s_nxt.take_left = s_r.len;
          cnt_load = 1'b0;
        end else begin
          // grant withdrawn before the address phase: give up quietly
          s_nxt.st = SQ_IDLE;
          s_nxt.ls = LS_IDLE;
          s_nxt.lgnt_n = 1'b1;
          s_nxt.frame_oe = 1'b0;
          s_nxt.irdy_oe = 1'b0;
        end
      end
      SQ_ADDR: begin
        cnt_load = 1'b1; // [RULE_10]
        // a request still present here asks for a chained transaction;
        // one raised later runs as a plain transaction after idle
        s_nxt.chain = req_any && chain_en &&
                      s_r.cmd[`FB2B_CMD_WRITE_BIT]; // [RULE_02] [RULE_04] [RULE_03]
        s_nxt.st = SQ_WAIT1;
      end
      SQ_WAIT1: begin
        // fast decode target answers now; slower ones keep us here
        // width is known once the target claims; indication shows in the second wait
        if (!devseln) begin // [RULE_14]
          s_nxt.st = SQ_WAIT2; // [RULE_18]
          s_nxt.wide_ind_n = ack64n || !s_r.wide_req; // [RULE_19]
          s_nxt.lgnt_n = gntn;
        end
      end
      SQ_WAIT2: begin
        s_nxt.wide_ind_n = ack64n || !s_r.wide_req; // [RULE_19]
        s_nxt.lgnt_n = gntn;
        s_nxt.irdyn = !s_nxt.ad_valid;
        if (burst_remaining_count == BURST_W'(1)) begin
          s_nxt.st = SQ_LAST;
          s_nxt.framen = 1'b1;
        end else begin
          s_nxt.st = SQ_DATA;
        end
      end
      SQ_DATA: begin
        s_nxt.lgnt_n = gntn;
        s_nxt.irdyn = !s_nxt.ad_valid;
        if (done) begin
          cnt_dec = 1'b1; // [RULE_21]
          if (burst_remaining_count == BURST_W'(2)) begin
            if (s_r.chain) begin
              s_nxt.st = SQ_FBWAIT;
              s_nxt.ls = LS_FB2B; // [RULE_22]
              s_nxt.irdyn = 1'b1;
            end else begin
              s_nxt.st = SQ_LAST;
              s_nxt.framen = 1'b1;
            end
          end
        end
      end
      SQ_FBWAIT: begin
        s_nxt.lgnt_n = gntn;
        s_nxt.st = SQ_LAST;
        s_nxt.framen = 1'b1;
        s_nxt.irdyn = !s_nxt.ad_valid;
      end
      SQ_LAST: begin
        s_nxt.lgnt_n = gntn;
        s_nxt.irdyn = !s_nxt.ad_valid;
        if (done) begin
          cnt_dec = 1'b1;
          xact_done = 1'b1;
          s_nxt.req64n = 1'b1;
          s_nxt.ad_oe = 1'b0;
          s_nxt.irdyn = 1'b1;
          s_nxt.wide_ind_n = 1'b1;
          s_nxt.chain = 1'b0;
          if (s_r.chain && req_any && !s_r.lgnt_n) begin
            // next transaction loads at once, one idle bus cycle before its address
            s_nxt.st = SQ_ADDR_LOAD; // [RULE_01]
            s_nxt.ls = LS_ADDR_LOAD;
            s_nxt.addr = local_data_in[31:0];
            s_nxt.cmd = local_cmd_byte_en_in[3:0];
            s_nxt.len = burst_length_in;
            s_nxt.wide_req = !local_req_wide_n;
          end else begin
            s_nxt.st = SQ_TURN;
            s_nxt.ls = LS_TERM;
            s_nxt.frame_oe = 1'b0;
          end
        end
      end
      SQ_TURN: begin
        s_nxt.st = SQ_IDLE;
        s_nxt.ls = LS_IDLE;
        s_nxt.lgnt_n = 1'b1;
        s_nxt.irdy_oe = 1'b0;
      end
      default: begin
        s_nxt.st = SQ_IDLE;
      end
    endcase

    // strobes only where a word may be read, never in wait cycles
    next_strobe_ok = (s_nxt.st == SQ_ADDR) || (s_nxt.st == SQ_DATA);
    s_nxt.strobe_n = !(!local_ready_n && next_strobe_ok && !s_nxt.hold_valid &&
                       s_nxt.take_left != '0); // [RULE_11] [RULE_12] [RULE_17]
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{st: SQ_IDLE, ls: LS_IDLE, reqn: 1'b1, lgnt_n: 1'b1, framen: 1'b1,
               frame_oe: 1'b0, irdyn: 1'b1, irdy_oe: 1'b0, req64n: 1'b1, ad_oe: 1'b0,
               strobe_n: 1'b1, wide_ind_n: 1'b1, wide_req: 1'b0, chain: 1'b0,
               ad: '0, cben: '0, ad_valid: 1'b0, hold: '0, hold_be: '0,
               hold_valid: 1'b0, addr: '0, cmd: '0, len: '0, take_left: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // output map
  assign reqn = s_r.reqn;
  assign local_grant_n = s_r.lgnt_n;
  assign local_master_state = s_r.ls;
  assign low_word_taken_n = s_r.strobe_n;
  assign high_word_taken_n = s_r.strobe_n || !s_r.wide_req;
  assign wide_transfer_ind_n = s_r.wide_ind_n;
  assign framen_o = s_r.framen;
  assign framen_oe = s_r.frame_oe;
  assign irdyn_o = s_r.irdyn;
  assign irdyn_oe = s_r.irdy_oe;
  assign req64n_o = s_r.req64n;
  assign req64n_oe = s_r.frame_oe;
  assign ad_o = s_r.ad;
  assign ad_oe = s_r.ad_oe;
  assign cben_o = s_r.cben;

  // bus request one cycle after an idle local request
  a_req_follows: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_06]
    (!local_req_wide_n && s_r.st == SQ_IDLE) |=> !reqn)
    else $error("bus request not raised after local request");

  // local grant only after bus grant on an idle bus
  a_grant_idle: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_07]
    ($fell(local_grant_n) && $past(s_r.st) == SQ_IDLE) |->
      (!$past(gntn) && $past(framen_i) && $past(irdyn_i)))
    else $error("local grant without idle granted bus");

  // address loading needs request and grant in the cycle before
  a_addr_loading: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_08]
    $rose(local_master_state == LS_ADDR_LOAD) |->
      (!$past(local_grant_n) && (!$past(local_req_wide_n) || !$past(local_req_32bit_n))))
    else $error("address loading without request and grant");

  // frame and address follow address loading with grant
  a_frame_start: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_09]
    (s_r.st == SQ_ADDR_LOAD && !gntn) |=>
      (!framen_o && framen_oe && ad_oe && local_master_state == LS_BUS_TRANS))
    else $error("frame not started after address loading");

  // counter holds the burst length right after the address phase
  a_burst_load: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_10]
    (s_r.st == SQ_ADDR) |=> (burst_remaining_count == $past(s_r.len)))
    else $error("burst counter not loaded");

  // a taken strobe always answers a ready from the cycle before
  a_strobe_ready: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_12]
    $fell(low_word_taken_n) |-> !$past(local_ready_n))
    else $error("strobe without prior local ready");

  // the two decision waits keep frame on, irdy off and strobes idle
  a_first_wait: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_17]
    (s_r.st == SQ_WAIT1) |-> (!framen_o && irdyn_o && low_word_taken_n))
    else $error("first wait cycle drives wrong levels");

  a_second_wait: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_18]
    (s_r.st == SQ_WAIT1 && !devseln) |=>
      (s_r.st == SQ_WAIT2 && !framen_o && irdyn_o && low_word_taken_n))
    else $error("second wait cycle missing");

  // counter steps down one after each completed data phase before the last one
  a_count_dec: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_21]
    (s_r.st == SQ_DATA && !irdyn_o && !trdyn) |=>
      (burst_remaining_count == $past(burst_remaining_count) - BURST_W'(1)))
    else $error("burst counter did not step");

  // chained last phase is preceded by one wait with irdy off
  a_fb2b_wait: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE_22]
    (s_r.st == SQ_FBWAIT) |-> (irdyn_o && low_word_taken_n &&
      local_master_state == LS_FB2B) ##1 (s_r.st == SQ_LAST && framen_o))
    else $error("fast back-to-back wait cycle wrong");
endmodule : pci_fb2b_master

// ==== verification/pci_far_target.sv ====
`timescale 1ns/100ps
// arbiter and fast or slow pci target standing on the far side of the master
module pci_far_target (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic reqn,
  input wire logic framen,
  input wire logic irdyn,
  output logic gntn,
  output logic devseln,
  output logic trdyn,
  output logic ack64n
);
  logic busy;
  logic [1:0] wait_cnt;

  // grant follows request one cycle later; a fast target claims the cycle after the address, a slow one two cycles later
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gntn <= 1'b1;
      busy <= 1'b0;
      wait_cnt <= 2'h0;
      {devseln, trdyn, ack64n} <= 3'h7;
    end else begin
      gntn <= reqn;
      if (!busy) begin
        if (!framen) begin
          busy <= 1'b1;
          wait_cnt <= slow ? 2'h2 : 2'h0;
          if (!slow) {devseln, trdyn, ack64n} <= 3'h0;
        end
      end else if (devseln) begin
        if (wait_cnt == 2'h1) {devseln, trdyn, ack64n} <= 3'h0; // late decode
        wait_cnt <= wait_cnt - 2'h1;
      end else if (framen && !irdyn) begin
        busy <= 1'b0;
        {devseln, trdyn, ack64n} <= 3'h7; // released lines go to pull-up level
      end
    end
  end
endmodule : pci_far_target

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic er;
  } apb_row_t;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, slow, er;
  logic [7:0] paddr, local_cmd_byte_en_in, cben_o;
  logic [31:0] pwdata, prdata, rd;
  logic local_req_32bit_n, local_req_wide_n, local_ready_n, local_grant_n, gntn, reqn;
  logic low_word_taken_n, high_word_taken_n, wide_transfer_ind_n, ad_oe, req64n_oe;
  logic framen_o, framen_oe, irdyn_o, irdyn_oe, req64n_o, devseln, trdyn, ack64n;
  logic framen_bus, irdyn_bus;
  logic [63:0] local_data_in, ad_o;
  logic [11:0] burst_length_in, burst_remaining_count;
  logic [3:0] local_master_state;
  int error_cnt, n_tests;
  apb_row_t rows [0:8] = '{
    '{1'b0, 8'h00, 32'h0, 32'h1, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h00, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h00, 32'h1, 32'h0, 1'b0},
    '{1'b1, 8'h20, 32'h0, 32'h0, 1'b1},
    '{1'b0, 8'h00, 32'h0, 32'h1, 1'b0}
  };

  // pulled-up bus lines seen by both parties
  assign framen_bus = framen_oe ? framen_o : 1'b1;
  assign irdyn_bus = irdyn_oe ? irdyn_o : 1'b1;

  pci_fb2b_master uut (
    .core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .local_req_32bit_n, .local_req_wide_n, .local_data_in, .local_cmd_byte_en_in,
    .burst_length_in, .local_ready_n, .local_grant_n, .local_master_state,
    .low_word_taken_n, .high_word_taken_n, .wide_transfer_ind_n, .burst_remaining_count,
    .gntn, .reqn, .framen_i(framen_bus), .framen_o, .framen_oe, .irdyn_i(irdyn_bus),
    .irdyn_o, .irdyn_oe, .req64n_o, .req64n_oe, .ad_o, .ad_oe, .cben_o, .devseln, .trdyn,
    .ack64n
  );

  pci_far_target far (
    .core_clk, .rst_b, .slow, .reqn, .framen(framen_bus), .irdyn(irdyn_bus), .gntn,
    .devseln, .trdyn, .ack64n
  );

  // clock generator
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // one apb transfer, waiting for pready; only the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  function automatic logic [63:0] word(input int j, input int i);
    return {32'hC0DE_0000 + 32'(j), 32'(i + 1)};
  endfunction : word

  function automatic logic [31:0] adr(input int j);
    return 32'h0001_0000 + 32'(j * 256);
  endfunction : adr

  // local master issuing nx wide transactions of len words with command cmd, checking the bus cycle by cycle
  task automatic run(input int nx, input logic [3:0] cmd, input int len, input logic fb_exp);
    int nl = 0, tk = 0, k = 0, tot = 0, ph = 0, cyc;
    logic [3:0] ps = 4'h0;
    logic pt = 1'b1, pg = 1'b1, pf = 1'b1, pr = 1'b1, fb = 1'b0, idle = 1'b0;
    @(posedge core_clk);
    local_req_wide_n <= 1'b0;
    local_data_in <= {32'h0, adr(0)};
    local_cmd_byte_en_in <= {4'h0, cmd};
    burst_length_in <= 12'(len);
    local_ready_n <= 1'b0;
    for (cyc = 0; cyc < 400 && !(nl == nx && tot == nx * len && ps == 4'h0); cyc++) begin
      @(posedge core_clk);
      if (ps == 4'h1) begin
        nl++;
        tk = 0;
        local_data_in <= word(nl - 1, 0);
        local_cmd_byte_en_in <= 8'h00;
        if (nl == nx) local_req_wide_n <= 1'b1;
      end else if (!pt) begin
        tk++;
        if (tk < len) begin
          local_data_in <= word(nl - 1, tk);
        end else if (nl < nx) begin
          local_data_in <= {32'h0, adr(nl)};
          local_cmd_byte_en_in <= {4'h0, cmd};
        end else begin
          local_ready_n <= 1'b1;
        end
      end
      #1;
      if (cyc == 0) chk(reqn, 1'b0);
      if (!pf && !pr) chk(reqn, 1'b0);
      if (local_master_state == 4'h1 && ps != 4'h1) chk(pg, 1'b0);
      chk(high_word_taken_n, low_word_taken_n);
      if (local_master_state == 4'h2 && ps == 4'h1) begin
        chk({framen_o, framen_oe, req64n_o, cben_o[3:0], ad_o[31:0]},
            {3'b010, cmd, adr(nl - 1)});
        chk(low_word_taken_n, 1'b0);
        ph = 1;
        k = 0;
      end else if (ph == 1) begin
        chk({framen_bus, irdyn_bus, low_word_taken_n, burst_remaining_count},
            {3'b011, 12'(len)});
        if (devseln === 1'b0) ph = 2;
      end else if (ph == 2) begin
        chk({framen_bus, irdyn_bus, low_word_taken_n, wide_transfer_ind_n,
             burst_remaining_count}, {4'b0110, 12'(len)});
        ph = 3;
      end else if (ph == 3 && !irdyn_bus && !trdyn) begin
        chk({ad_o, burst_remaining_count}, {word(nl - 1, k), 12'(len - k)});
        k++;
        tot++;
        if (k == len) ph = 0;
      end
      if (local_master_state == 4'h3 && ps == 4'h2) begin
        fb = 1'b1;
        chk({irdyn_bus, low_word_taken_n}, 2'b11);
      end
      if (local_master_state == 4'h0 && nl > 0 && nl < nx) idle = 1'b1;
      ps = local_master_state;
      pt = low_word_taken_n;
      pg = local_grant_n;
      pf = framen_bus;
      pr = local_req_wide_n;
    end
    chk(fb, fb_exp);
    if (nx > 1) chk(idle, !fb_exp);
    chk(cyc < 400, 1'b1);
    @(posedge core_clk);
    local_ready_n <= 1'b1;
  endtask : run

  // main sequence: registers, transfers, then a reset in mid-request
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow, rst_b} = '0;
    {local_req_32bit_n, local_req_wide_n, local_ready_n} = 3'h7;
    {local_data_in, local_cmd_byte_en_in, burst_length_in} = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk(er, rows[i].er);
      if (!rows[i].w) chk(rd, rows[i].e);
    end
    run(2, 4'h7, 2, 1'b1);
    run(2, 4'h6, 2, 1'b0);
    apb(1'b1, 8'h00, 32'h0, rd, er);
    run(2, 4'h7, 1, 1'b0);
    apb(1'b1, 8'h00, 32'h1, rd, er);
    slow <= 1'b1;
    run(1, 4'h7, 3, 1'b0);
    slow <= 1'b0;
    apb(1'b0, 8'h08, 32'h0, rd, er);
    chk(rd, 32'h7);
    @(posedge core_clk);
    local_req_32bit_n <= 1'b0;
    local_ready_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    chk({low_word_taken_n, high_word_taken_n, req64n_o, local_master_state},
        {3'b011, 4'h2});
    @(posedge core_clk);
    rst_b <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({reqn, local_grant_n, low_word_taken_n, framen_oe, ad_oe, local_master_state},
        {5'b11100, 4'h0});
    {local_req_32bit_n, local_ready_n} <= 2'b11;
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({reqn, local_grant_n, local_master_state}, {2'b11, 4'h0});
    give_verdict();
  end

  // watchdog against a hung handshake
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
